// file: design/bus_if_pkg.sv
/*
  Constants, enums and carrier structs for the CPU external bus interface.
  Assumes one clock domain, active-low asynchronous reset.
*/
// Notes on behaviour
// - One ungated clock, rising edge does all.
// - Async low reset clears every flop.
// - Program port: 22-bit address, 16-bit data.
// - Program words; byte loads pick even low.
// - Phase high first clock, low second.
// - Program read strobe one clock; data then.
// - Program write strobe one clock exactly.
// - Program and data write buses change only on writes.
// - Data port: 24-bit address, 8-bit data.
// - Explicit loads and stores use data port.
// - Data read strobe one clock; byte then.
// - Data write strobe one clock exactly.
// - Register bus one clock, never read+write.
// - Window maps to 6-bit address minus 0x20.
// - Internal registers raise no external strobes; window loads and stores still strobe the data port.
// - Register address valid only with strobes; also driven on internal accesses.
// - Register read data taken only when external.
// - Eight fixed-vector requests plus internal one.
// - Acknowledge two clocks; vector strobe second.
// - Internal request arrives clock-synchronous.
// - Vector loads low counter byte, rest zero.
// - One setup clock, then fetch word zero.
// - Idle register address and data are zero.
package bus_if_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PADDR_W   = 22;
  localparam int PDATA_W   = 16;
  localparam int DADDR_W   = 24;
  localparam int DDATA_W   = 8;
  localparam int IOADDR_W  = 6;
  localparam int IRQ_EXT_N = 8;
  localparam int IRQ_IDX_W = 3;
  localparam int VEC_W     = 8;

  // ----------------------------------------
  // Addresses and reset values
  // ----------------------------------------
  localparam logic [DADDR_W-1:0] SFR_BASE = 24'h00_0020;
  localparam logic [DADDR_W-1:0] SFR_LAST = 24'h00_005F;
  localparam logic [PADDR_W-1:0] PC_RESET = 22'h00_0000;
  localparam logic [PADDR_W-1:0] PC_STEP  = 22'h00_0001;
  // Fixed vector spacing and base, plain defaults
  localparam logic [PADDR_W-1:0] EXT_VEC_BASE = 22'h00_0002;
  localparam logic [PADDR_W-1:0] EXT_VEC_STEP = 22'h00_0002;
  // I/O addresses served inside the core
  localparam logic [63:0] INTERNAL_IO_MASK = 64'hE000_0C00_4000_0000;

  // ----------------------------------------
  // Enums
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE   = 3'b000,  // No transfer
    OP_FETCH  = 3'b001,  // Instruction word fetch
    OP_PBYTE  = 3'b010,  // load_program_byte, byte address
    OP_PWRITE = 3'b011,  // Program word write
    OP_DLOAD  = 3'b100,  // indirect_load
    OP_DSTORE = 3'b101,  // displaced_store
    OP_IOIN   = 3'b110,  // Implicit register read
    OP_IOOUT  = 3'b111   // Implicit register write
  } op_kind_e;

  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10,
    ST_SETUP  = 2'b11
  } state_e;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    op_kind_e           kind;   // What to do
    logic               jump;   // Fetch from addr, not counter
    logic [DADDR_W-1:0] addr;   // Byte, word or I/O address
    logic [PDATA_W-1:0] wdata;  // Write word or byte
  } bus_op_s;

  typedef struct packed {
    logic               valid;  // One-clock read result
    logic [PDATA_W-1:0] data;   // Word, or byte in low bits
  } bus_rsp_s;

endpackage

// file: design/addr_route.sv
/*
  Address decode for the register window.
  Assumes a stable latched address from the cycle sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module addr_route
  import bus_if_pkg::*;
(
  input  wire logic [DADDR_W-1:0]  addr,
  input  wire logic                is_io,
  output logic                     to_sfr,
  output logic [IOADDR_W-1:0]      io_addr,
  output logic                     sfr_external
);
  logic [DADDR_W-1:0] offset;  // Distance from window base

  // Window test and translation
  always_comb begin
    offset       = addr - SFR_BASE;
    to_sfr       = is_io || (addr >= SFR_BASE && addr <= SFR_LAST);
    io_addr      = is_io ? addr[IOADDR_W-1:0] : offset[IOADDR_W-1:0];
    sfr_external = !INTERNAL_IO_MASK[io_addr];
  end
endmodule
`default_nettype wire

// file: design/irq_select.sv
/*
  Interrupt priority selection.
  Assumes requests are levels synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_select
  import bus_if_pkg::*;
(
  input  wire logic [IRQ_EXT_N-1:0] ext_req,
  input  wire logic                 int_req,
  output logic                      ext_any,
  output logic [IRQ_IDX_W-1:0]      ext_idx,
  output logic                      any_req
);
  // Lowest index wins; internal only when no external
  always_comb begin
    ext_idx = '0;
    for (int i = IRQ_EXT_N - 1; i >= 0; i--) begin
      if (ext_req[i]) begin
        ext_idx = IRQ_IDX_W'(i);
      end
    end
    ext_any = |ext_req;
    any_req = ext_any || int_req;
  end
endmodule
`default_nettype wire

// file: design/cpu_bus_interface.sv
/*
  Two-clock machine cycle sequencer driving program, data and
  register buses plus interrupt acknowledge.
  Assumes the core holds its request until core_ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_interface
  import bus_if_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire bus_op_s              core_op,
  output logic                      core_ready,
  output bus_rsp_s                  core_rsp,
  input  wire logic                 int_enable,
  output logic                      irq_taken,
  input  wire logic [DDATA_W-1:0]   io_int_rdata,
  output logic [PADDR_W-1:0]        pc_value,
  output logic                      cycle_phase,
  output logic [PADDR_W-1:0]        pmem_addr,
  output logic                      pmem_rd,
  output logic                      pmem_wr,
  output logic [PDATA_W-1:0]        pmem_wdata,
  input  wire logic [PDATA_W-1:0]   pmem_rdata,
  output logic [DADDR_W-1:0]        dmem_addr,
  output logic                      dmem_rd,
  output logic                      dmem_wr,
  output logic [DDATA_W-1:0]        dmem_wdata,
  input  wire logic [DDATA_W-1:0]   dmem_rdata,
  output logic [IOADDR_W-1:0]       sfr_addr,
  output logic                      sfr_rd,
  output logic                      sfr_wr,
  output logic [DDATA_W-1:0]        sfr_wdata,
  input  wire logic [DDATA_W-1:0]   sfr_rdata,
  input  wire logic [IRQ_EXT_N-1:0] ireq_ext,
  input  wire logic                 ireq_int,
  output logic                      int_ack,
  output logic                      ivec_rd,
  input  wire logic [VEC_W-1:0]     ivec_rdata
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  state_e                state;        // Sequencer state
  state_e                next_state;   // Its next value
  bus_op_s               cur_op;       // Request of this cycle
  logic                  cur_ack;      // Cycle is an acknowledge
  logic                  cur_ack_int;  // Acknowledge of internal request
  logic [IRQ_IDX_W-1:0]  ack_idx;      // External request acknowledged
  logic [PADDR_W-1:0]    pc;           // Program counter, words
  logic [PADDR_W-1:0]    fetch_addr;   // Word to fetch
  logic [PADDR_W-1:0]    ext_vector;   // Fixed vector of chosen request
  logic [PADDR_W-1:0]    vec_pc;       // Vector of the acknowledged request
  logic                  cycle_start;  // Next edge opens a cycle
  logic                  to_second;    // Next edge enters second clock
  logic                  ack_now;      // Acknowledge replaces fetch
  logic                  ext_any;      // Some external request
  logic [IRQ_IDX_W-1:0]  ext_idx;      // Lowest external request
  logic                  any_req;      // Any request pending
  logic                  to_sfr;       // Cycle uses register bus
  logic [IOADDR_W-1:0]   io_addr;      // Translated register address
  logic                  sfr_external; // Register lives outside
  logic                  is_io;        // Implicit register access
  logic                  is_read;      // Cycle returns data
  logic [DDATA_W-1:0]    sfr_data;     // Register read source

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  irq_select u_irq (
    .ext_req (ireq_ext),
    .int_req (ireq_int),
    .ext_any (ext_any),
    .ext_idx (ext_idx),
    .any_req (any_req)
  );

  addr_route u_route (
    .addr         (cur_op.addr),
    .is_io        (is_io),
    .to_sfr       (to_sfr),
    .io_addr      (io_addr),
    .sfr_external (sfr_external)
  );

  // Decodes of the current cycle
  always_comb begin
    is_io       = (cur_op.kind == OP_IOIN) || (cur_op.kind == OP_IOOUT);
    is_read     = (cur_op.kind == OP_FETCH) || (cur_op.kind == OP_PBYTE)
               || (cur_op.kind == OP_DLOAD) || (cur_op.kind == OP_IOIN);
    cycle_start = (state == ST_SETUP) || (state == ST_SECOND);
    to_second   = (state == ST_FIRST);
    cycle_phase = (state == ST_FIRST);
    // Acknowledge only at an instruction boundary
    ack_now     = (state == ST_SECOND) && int_enable && any_req
               && (core_op.kind == OP_FETCH);
    core_ready  = (state == ST_SECOND) && !ack_now;
    ext_vector  = EXT_VEC_BASE + PADDR_W'(ack_idx) * EXT_VEC_STEP;
    vec_pc      = cur_ack_int ? {{(PADDR_W - VEC_W){1'b0}}, ivec_rdata} : ext_vector;
    // Plain fetch right after an acknowledge goes to the vector
    fetch_addr  = core_op.jump ? core_op.addr[PADDR_W-1:0] : (cur_ack ? vec_pc : pc);
    sfr_data    = sfr_external ? sfr_rdata : io_int_rdata;
    pc_value    = pc;
  end

  // ----------------------------------------
  // Machine cycle sequencer
  // ----------------------------------------
  // Next state of the two-clock cycle
  always_comb begin
    case (state)
      ST_RESET:  next_state = ST_SETUP;
      ST_SETUP:  next_state = ST_FIRST;
      ST_FIRST:  next_state = ST_SECOND;
      ST_SECOND: next_state = ST_FIRST;
      default:   next_state = ST_RESET;
    endcase
  end

  // State register, single rising-edge clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Request latch at each cycle start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur_op      <= '0;
      cur_ack     <= 1'b0;
      cur_ack_int <= 1'b0;
      ack_idx     <= '0;
    end else if (cycle_start) begin
      if (state == ST_SETUP) begin
        // First fetch after the setup clock
        cur_op  <= '{kind: OP_FETCH, default: '0};
        cur_ack <= 1'b0;
      end else if (ack_now) begin
        // Fetch aborted, acknowledge instead
        cur_op      <= '0;
        cur_ack     <= 1'b1;
        cur_ack_int <= !ext_any;
        ack_idx     <= ext_idx;
      end else begin
        cur_op  <= core_op;
        cur_ack <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Program memory port
  // ----------------------------------------
  // Counter, address and write word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc         <= PC_RESET;
      pmem_addr  <= PC_RESET;
      pmem_wdata <= '0;
    end else if (state == ST_SETUP) begin
      pmem_addr <= PC_RESET;
      pc        <= PC_RESET + PC_STEP;
    end else if (cycle_start && !ack_now) begin
      // Vector lands as the acknowledge cycle closes
      if (cur_ack) begin
        pc <= vec_pc;
      end
      case (core_op.kind)
        OP_FETCH: begin
          pmem_addr <= fetch_addr;
          pc        <= fetch_addr + PC_STEP;
        end
        OP_PBYTE: begin
          pmem_addr <= core_op.addr[PADDR_W:1];
        end
        OP_PWRITE: begin
          pmem_addr  <= core_op.addr[PADDR_W-1:0];
          pmem_wdata <= core_op.wdata;
        end
        default: begin
          pmem_addr <= pmem_addr;
        end
      endcase
    end else if (state == ST_SECOND && cur_ack) begin
      // Repeated acknowledge still loads the vector
      pc <= vec_pc;
    end
  end

  // ----------------------------------------
  // Data memory port
  // ----------------------------------------
  // Address and write byte, held between uses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dmem_addr  <= '0;
      dmem_wdata <= '0;
    end else if (cycle_start && !ack_now && state == ST_SECOND) begin
      if (core_op.kind == OP_DLOAD) begin
        dmem_addr <= core_op.addr;
      end else if (core_op.kind == OP_DSTORE) begin
        dmem_addr  <= core_op.addr;
        dmem_wdata <= core_op.wdata[DDATA_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Strobes, second clock only
  // ----------------------------------------
  // Each strobe set entering second clock, cleared after
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pmem_rd <= 1'b0;
      pmem_wr <= 1'b0;
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
    end else if (to_second) begin
      pmem_rd <= (cur_op.kind == OP_FETCH) || (cur_op.kind == OP_PBYTE);
      pmem_wr <= (cur_op.kind == OP_PWRITE);
      dmem_rd <= (cur_op.kind == OP_DLOAD);
      dmem_wr <= (cur_op.kind == OP_DSTORE);
    end else begin
      pmem_rd <= 1'b0;
      pmem_wr <= 1'b0;
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // One-clock transfer in the second clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sfr_addr  <= '0;
      sfr_wdata <= '0;
      sfr_rd    <= 1'b0;
      sfr_wr    <= 1'b0;
    end else if (to_second && to_sfr) begin
      // Address also carries internal traffic
      sfr_addr  <= io_addr;
      sfr_rd    <= sfr_external && ((cur_op.kind == OP_DLOAD) || (cur_op.kind == OP_IOIN));
      sfr_wr    <= sfr_external && ((cur_op.kind == OP_DSTORE) || (cur_op.kind == OP_IOOUT));
      if ((cur_op.kind == OP_DSTORE) || (cur_op.kind == OP_IOOUT)) begin
        sfr_wdata <= cur_op.wdata[DDATA_W-1:0];
      end else begin
        sfr_wdata <= '0;
      end
    end else begin
      // Idle bus reads as zero
      sfr_addr  <= '0;
      sfr_wdata <= '0;
      sfr_rd    <= 1'b0;
      sfr_wr    <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read results
  // ----------------------------------------
  // Sampled at the edge that ends the cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_rsp <= '0;
    end else if (state == ST_SECOND && is_read) begin
      core_rsp.valid <= 1'b1;
      case (cur_op.kind)
        OP_FETCH: core_rsp.data <= pmem_rdata;
        OP_PBYTE: begin
          // Even byte address is the low byte
          if (cur_op.addr[0]) begin
            core_rsp.data <= {8'h00, pmem_rdata[15:8]};
          end else begin
            core_rsp.data <= {8'h00, pmem_rdata[7:0]};
          end
        end
        OP_DLOAD: begin
          if (to_sfr) begin
            core_rsp.data <= {8'h00, sfr_data};
          end else begin
            core_rsp.data <= {8'h00, dmem_rdata};
          end
        end
        default: core_rsp.data <= {8'h00, sfr_data};
      endcase
    end else begin
      core_rsp.valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt acknowledge
  // ----------------------------------------
  // Acknowledge over both clocks, vector strobe in second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_ack   <= 1'b0;
      ivec_rd   <= 1'b0;
      irq_taken <= 1'b0;
    end else begin
      if (cycle_start) begin
        int_ack <= ack_now;
      end
      ivec_rd   <= to_second && cur_ack && cur_ack_int;
      irq_taken <= (state == ST_SECOND) && cur_ack;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  phase_alternates_a: assert property (cycle_phase |=> !cycle_phase ##1 cycle_phase)
    else $error("phase does not alternate");
  pmem_rd_width_a: assert property (pmem_rd |-> !cycle_phase ##1 !pmem_rd)
    else $error("program read strobe wrong");
  pmem_wr_width_a: assert property (pmem_wr |-> !cycle_phase ##1 !pmem_wr)
    else $error("program write strobe wrong");
  dmem_strobe_a: assert property ((dmem_rd || dmem_wr) |-> !cycle_phase ##1 !(dmem_rd || dmem_wr))
    else $error("data strobe wrong");
  pwdata_hold_a: assert property ($changed(pmem_wdata) |-> cycle_phase && cur_op.kind == OP_PWRITE)
    else $error("program write data moved");
  dwdata_hold_a: assert property ($changed(dmem_wdata) |-> cycle_phase && cur_op.kind == OP_DSTORE)
    else $error("data write data moved");
  sfr_exclusive_a: assert property (!(sfr_rd && sfr_wr))
    else $error("register read and write together");
  sfr_idle_zero_a: assert property (cycle_phase |-> sfr_addr == '0 && sfr_wdata == '0 && !sfr_rd)
    else $error("register bus not idle");
  sfr_translate_a: assert property ((dmem_rd || dmem_wr) && dmem_addr >= SFR_BASE && dmem_addr <= SFR_LAST
                                    |-> sfr_addr == IOADDR_W'(dmem_addr - SFR_BASE))
    else $error("register address not translated");
  ack_two_a: assert property ($rose(int_ack) |-> cycle_phase ##1 int_ack ##1 !int_ack)
    else $error("acknowledge not two clocks");
  ivec_place_a: assert property (ivec_rd |-> int_ack && !cycle_phase)
    else $error("vector strobe misplaced");
  vec_load_a: assert property (ivec_rd && core_op.kind != OP_FETCH
                               |=> pc_value == {{(PADDR_W - VEC_W){1'b0}}, $past(ivec_rdata)})
    else $error("vector not loaded");
  first_fetch_a: assert property (state == ST_SETUP |=> pmem_addr == PC_RESET ##1 pmem_rd)
    else $error("first fetch not at zero");
  prio_low_a: assert property ($rose(int_ack) && $past(ireq_ext[0]) |-> ack_idx == '0 && !cur_ack_int)
    else $error("lowest request not first");

  fetch_seen_c: cover property (pmem_rd ##2 pmem_rd);
  sfr_store_c: cover property (dmem_wr && sfr_wr);
  int_ack_c: cover property (ivec_rd ##1 irq_taken);
  ext_ack_c: cover property (int_ack && !cur_ack_int ##1 int_ack);

endmodule
`default_nettype wire

// file: test/mem_partner.sv
/*
  Far side: program and data memories, external registers, vector source.
  Assumes registered one-clock strobes from the bus interface.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_partner
  import bus_if_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic [PADDR_W-1:0]  pmem_addr,
  input  wire logic                pmem_rd,
  input  wire logic                pmem_wr,
  input  wire logic [PDATA_W-1:0]  pmem_wdata,
  output logic      [PDATA_W-1:0]  pmem_rdata,
  input  wire logic [DADDR_W-1:0]  dmem_addr,
  input  wire logic                dmem_rd,
  input  wire logic                dmem_wr,
  input  wire logic [DDATA_W-1:0]  dmem_wdata,
  output logic      [DDATA_W-1:0]  dmem_rdata,
  input  wire logic [IOADDR_W-1:0] sfr_addr,
  input  wire logic                sfr_rd,
  input  wire logic                sfr_wr,
  input  wire logic [DDATA_W-1:0]  sfr_wdata,
  output logic      [DDATA_W-1:0]  sfr_rdata,
  input  wire logic                ivec_rd,
  output logic      [VEC_W-1:0]    ivec_rdata
);
  logic [PDATA_W-1:0] pm [256];  // Program words
  logic [DDATA_W-1:0] dm [256];  // Data bytes
  logic [DDATA_W-1:0] rg [64];   // External registers
  // Known contents: word i holds {i, ~i}
  initial begin
    for (int i = 0; i < 256; i++) begin
      pm[i] = {i[7:0], ~i[7:0]};
      dm[i] = 8'h00;
    end
    for (int i = 0; i < 64; i++) begin
      rg[i] = 8'h80 | i[7:0];
    end
  end
  // Stores land at the edge closing the strobe clock
  always @(posedge clk_sys) begin
    if (pmem_wr) pm[pmem_addr[7:0]] <= pmem_wdata;
    if (dmem_wr) dm[dmem_addr[7:0]] <= dmem_wdata;
    if (sfr_wr) rg[sfr_addr] <= sfr_wdata;
  end
  // Read data only good under a strobe, inverted otherwise
  assign pmem_rdata = pmem_rd ? pm[pmem_addr[7:0]] : ~pm[pmem_addr[7:0]];
  assign dmem_rdata = dmem_rd ? dm[dmem_addr[7:0]] : ~dm[dmem_addr[7:0]];
  assign sfr_rdata  = sfr_rd ? rg[sfr_addr] : ~rg[sfr_addr];
  assign ivec_rdata = ivec_rd ? 8'hA5 : 8'h5A;
endmodule
`default_nettype wire

// file: test/cpu_external_bus_interface_bench.sv
/*
  Self-checking bench for the bus interface.
  Assumes the far-side model in mem_partner; inputs move at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_external_bus_interface_bench
  import bus_if_pkg::*;
;
  logic clk_sys, reset_n, core_ready, int_enable, irq_taken, cycle_phase;
  logic pmem_rd, pmem_wr, dmem_rd, dmem_wr, sfr_rd, sfr_wr, ireq_int, int_ack, ivec_rd;
  bus_op_s              core_op;
  bus_rsp_s             core_rsp;
  logic [PADDR_W-1:0]   pc_value, pmem_addr;
  logic [PDATA_W-1:0]   pmem_wdata, pmem_rdata, rd;
  logic [DADDR_W-1:0]   dmem_addr;
  logic [DDATA_W-1:0]   io_int_rdata, dmem_wdata, dmem_rdata, sfr_wdata, sfr_rdata;
  logic [IOADDR_W-1:0]  sfr_addr;
  logic [IRQ_EXT_N-1:0] ireq_ext;
  logic [VEC_W-1:0]     ivec_rdata;
  int                   err_count, num_checks, sfr_cnt, dmem_cnt;

  cpu_bus_interface u_dut (.clk_sys, .reset_n, .core_op, .core_ready, .core_rsp, .int_enable,
    .irq_taken, .io_int_rdata, .pc_value, .cycle_phase, .pmem_addr, .pmem_rd, .pmem_wr,
    .pmem_wdata, .pmem_rdata, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_wdata, .dmem_rdata,
    .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata, .ireq_ext, .ireq_int, .int_ack,
    .ivec_rd, .ivec_rdata);
  mem_partner u_mem (.clk_sys, .pmem_addr, .pmem_rd, .pmem_wr,
    .pmem_wdata, .pmem_rdata, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_wdata, .dmem_rdata,
    .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata, .ivec_rd, .ivec_rdata);

  // Clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Strobe counters for routing checks
  always @(posedge clk_sys) begin
    sfr_cnt <= sfr_cnt + int'(sfr_rd | sfr_wr);
    dmem_cnt <= dmem_cnt + int'(dmem_rd | dmem_wr);
  end

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One machine cycle request; ends in the clock after the strobe
  task automatic op(input op_kind_e k, input logic [23:0] a, input logic [15:0] w);
    int n;
    core_op = '{kind: k, jump: (k == OP_FETCH), addr: a, wdata: w};
    n = 0;
    #1;
    while (core_ready !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    sfr_cnt = 0;
    dmem_cnt = 0;
    @(negedge clk_sys);
    core_op.kind = OP_IDLE;
    repeat (2) @(negedge clk_sys);
    rd = core_rsp.data;
    chk("rsp_valid", k inside {OP_FETCH, OP_PBYTE, OP_DLOAD, OP_IOIN}, core_rsp.valid);
  endtask

  task automatic t_reset();
    chk("reset_rd", 0, pmem_rd);
    @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    chk("setup_ph", 0, cycle_phase);
    @(negedge clk_sys);
    chk("first_ph", 1, cycle_phase);
    chk("first_addr", 0, pmem_addr);
    @(negedge clk_sys);
    chk("first_rd", 1, pmem_rd);
    chk("second_ph", 0, cycle_phase);
  endtask

  task automatic t_prog();
    op(OP_PBYTE, 24'h00_0005, 16'h0000);
    chk("byte_hi", 16'h0002, rd);
    op(OP_PBYTE, 24'h00_0004, 16'h0000);
    chk("byte_lo", 16'h00FD, rd);
    op(OP_PWRITE, 24'h00_0010, 16'hBEEF);
    op(OP_FETCH, 24'h00_0010, 16'h0000);
    chk("word_back", 16'hBEEF, rd);
    chk("paddr", 22'h00_0010, pmem_addr);
  endtask

  task automatic t_data();
    op(OP_DSTORE, 24'h12_0040, 16'h005A);
    chk("daddr", 24'h12_0040, dmem_addr);
    op(OP_DLOAD, 24'h12_0040, 16'h0000);
    chk("dload", 16'h005A, rd);
    chk("pwdata_hold", 16'hBEEF, pmem_wdata);
    op(OP_DLOAD, 24'h00_0003, 16'h0000);
    chk("reg_region", 1, dmem_cnt);
    chk("dwdata_hold", 8'h5A, dmem_wdata);
  endtask

  task automatic t_sfr();
    op(OP_IOOUT, 24'h00_0007, 16'h0033);
    chk("out_strobe", 1, sfr_cnt);
    op(OP_IOIN, 24'h00_0007, 16'h0000);
    chk("in_back", 16'h0033, rd);
    op(OP_DLOAD, 24'h00_0025, 16'h0000);
    chk("window", 16'h0085, rd);
    chk("window_sfr", 1, sfr_cnt);
    chk("window_dmem", 1, dmem_cnt);
    op(OP_IOIN, 24'h00_001E, 16'h0000);
    chk("inner_data", 16'h003C, rd);
    chk("inner_quiet", 0, sfr_cnt);
    chk("idle_addr", 0, sfr_addr);
    chk("idle_wdata", 0, sfr_wdata);
  endtask

  task automatic t_irq(input logic [7:0] e, input logic i, input logic [21:0] pc, input int nv);
    int na, nr, n;
    na = 0;
    nr = 0;
    ireq_ext = e;
    ireq_int = i;
    int_enable = 1'b1;
    core_op = '{kind: OP_FETCH, jump: 1'b0, addr: 24'h00_0000, wdata: 16'h0000};
    for (n = 0; n < 20; n++) begin
      @(negedge clk_sys);
      na += int'(int_ack);
      nr += int'(ivec_rd);
      // Core drops its enable and its fetch once the acknowledge starts
      if (int_ack === 1'b1) begin
        int_enable = 1'b0;
        core_op.kind = OP_IDLE;
      end
      if (irq_taken === 1'b1) break;
    end
    ireq_ext = 8'h00;
    ireq_int = 1'b0;
    int_enable = 1'b0;
    core_op.kind = OP_IDLE;
    chk("ack_len", 2, na);
    chk("vec_rd", nv, nr);
    chk("vector_pc", pc, pc_value);
    repeat (2) @(negedge clk_sys);
  endtask

  // Hang guard, well past the expected run
  initial begin
    #20000;
    err_count++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    int_enable = 1'b0;
    ireq_ext = 8'h00;
    ireq_int = 1'b0;
    io_int_rdata = 8'h3C;
    core_op = '0;
    err_count = 0;
    num_checks = 0;
    sfr_cnt = 0;
    dmem_cnt = 0;
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_prog();
    t_data();
    t_sfr();
    t_irq(8'h14, 1'b0, 22'h00_0006, 0);
    t_irq(8'h80, 1'b1, 22'h00_0010, 0);
    t_irq(8'h00, 1'b1, 22'h00_00A5, 1);
    t_irq(8'h81, 1'b0, 22'h00_0002, 0);
    summarize();
  end
endmodule
`default_nettype wire
